// *** strobe_timer.sv ***
// Strobe width timer producing a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module strobe_timer
(
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic start,
	output logic      done
);
	import token_pkg::*;

	typedef struct packed
	{
		logic [1:0] cnt;
		logic       busy;
		logic       done;
	} timer_state_t;

	timer_state_t state_r;
	timer_state_t state_nxt;

	// ------------------------------------------------------------
	// Count the strobe width in reference cycles
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt      = state_r;
		state_nxt.done = 1'b0;
		if (start)
		begin
			state_nxt.cnt  = STROBE_CNT;
			state_nxt.busy = 1'b1;
		end
		else if (state_r.busy)
		begin
			if (state_r.cnt <= 2'h1)
			begin
				state_nxt.busy = 1'b0;
				state_nxt.done = 1'b1;
				state_nxt.cnt  = CNT_RESET;
			end
			else
				state_nxt.cnt = state_r.cnt - 2'h1;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign done = state_r.done;
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench of the token host against the flag device model
`timescale 1ns/1ps
`default_nettype none
module tb;
	import token_pkg::*;
	logic        ref_clk, reset_n, req_valid, req_ready, rsp_valid;
	request_t    req;
	result_t     rsp;
	pins_t       pins;
	logic [15:0] data_in;
	logic        b_we_n, b_d0, b_flag;
	logic [2:0]  b_idx;
	int          err_count, n_compared;
	token_host token_host_i (.ref_clk, .reset_n, .req_valid, .req,
		.req_ready, .rsp_valid, .rsp, .pins, .data_in);
	token_device token_device_i (.pins, .b_we_n, .b_idx, .b_d0, .b_flag,
		.data_in);
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: %h %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Host request, expected {granted, flag}
	task automatic op(input cmd_t c, input logic [2:0] i, input logic [1:0] e);
		int n;
		@(negedge ref_clk);
		req_valid = 1'b1;
		req = '{c, i};
		@(negedge ref_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 100)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 100)
			err_count++;
		check(rsp, e);
	endtask
	// Far-side write, one cycle strobe
	task automatic bw(input logic [2:0] i, input logic v);
		@(negedge ref_clk);
		b_idx = i;
		b_d0 = v;
		b_we_n = 1'b0;
		@(negedge ref_clk);
		b_we_n = 1'b1;
	endtask
	task automatic bf(input logic [2:0] i, input logic e);
		@(negedge ref_clk);
		b_idx = i;
		#1 check({1'b0, b_flag}, {1'b0, e});
	endtask
	task automatic t_init;
		op(CMD_INIT, 3'h0, 2'h1);
		for (int i = 0; i < 8; i++)
			bw(3'(i), 1'b1);
		for (int i = 0; i < 8; i++)
			op(CMD_READ, 3'(i), 2'h1);
	endtask
	task automatic t_claim;
		op(CMD_CLAIM, 3'h3, 2'h2);
		bw(3'h3, 1'b0);
		bf(3'h3, 1'b1);
		op(CMD_READ, 3'h3, 2'h2);
		op(CMD_RELEASE, 3'h3, 2'h1);
		bf(3'h3, 1'b0);
		op(CMD_READ, 3'h3, 2'h1);
		bw(3'h3, 1'b1);
		op(CMD_CLAIM, 3'h3, 2'h2);
	endtask
	task automatic t_lose;
		bw(3'h5, 1'b0);
		op(CMD_CLAIM, 3'h5, 2'h1);
		op(CMD_RELEASE, 3'h5, 2'h1);
		bw(3'h5, 1'b1);
		op(CMD_READ, 3'h5, 2'h1);
		bf(3'h5, 1'b1);
	endtask
	// Watchdog sized well past the expected run
	initial
	begin
		#(25 * 6000);
		err_count++;
		test_done;
	end
	initial
	begin
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		b_we_n = 1'b1;
		b_idx = 3'h0;
		b_d0 = 1'b1;
		err_count = 0;
		n_compared = 0;
		repeat (10) @(negedge ref_clk);
		reset_n = 1'b1;
		t_init;
		t_claim;
		t_lose;
		test_done;
	end
endmodule
bind token_host token_checker token_checker_i (.ref_clk, .reset_n,
	.req_valid, .req, .req_ready, .rsp_valid, .rsp, .pins, .data_in);
`default_nettype wire

// *** token_checker.sv ***
// Port checker for the token flag host
`timescale 1ns/1ps
`default_nettype none
module token_checker
(
	input wire logic                 ref_clk,
	input wire logic                 reset_n,
	input wire logic                 req_valid,
	input wire token_pkg::request_t  req,
	input wire logic                 req_ready,
	input wire logic                 rsp_valid,
	input wire token_pkg::result_t   rsp,
	input wire token_pkg::pins_t     pins,
	input wire logic [15:0]          data_in
);
	import token_pkg::*;
	// ----------
	// Helpers
	// ----------
	logic tk;
	logic rd;
	logic wr;
	assign tk = req_valid && req_ready;
	assign rd = !pins.token_space_select_n && !pins.output_enable_n;
	assign wr = !pins.token_space_select_n && !pins.write_n;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence claim_wr;
		(wr && !pins.data_out[0])[*3];
	endsequence
	sequence read_win;
		rd[*3];
	endsequence
	// ----------
	// Checks
	// ----------
	claim_order_a: assert property (tk && req.cmd == CMD_CLAIM |=>
		claim_wr ##[2:4] read_win) else $error("claim not write then read");
	release_one_a: assert property (tk && req.cmd == CMD_RELEASE |=>
		wr && pins.data_out[0] && pins.addr[2:0] == $past(req.index))
		else $error("release did not write one");
	init_one_a: assert property (tk && req.cmd == CMD_INIT |=>
		wr && pins.data_out[0]) else $error("init did not write one");
	read_index_a: assert property (tk && req.cmd == CMD_READ |=>
		rd && pins.addr[2:0] == $past(req.index))
		else $error("read index wrong");
	read_gap_a: assert property (read_win |=> !rd)
		else $error("read not deselected");
	read_answer_a: assert property (tk && req.cmd == CMD_READ |->
		##[4:5] rsp_valid) else $error("read answer late");
	result_pair_a: assert property (rsp_valid |->
		rsp.granted != rsp.flag) else $error("result pair wrong");
	busy_hold_a: assert property (tk |=> !req_ready)
		else $error("ready while busy");
	write_drive_a: assert property (wr |-> pins.data_oe && !rd)
		else $error("write without data drive");
	read_flag_a: assert property (tk && req.cmd == CMD_READ |->
		##5 (rsp_valid && rsp.flag == $past(data_in[0], 4)))
		else $error("read flag not taken from data lines");
endmodule
`default_nettype wire

// *** token_device.sv ***
// Two-port token flag device model facing the host
`timescale 1ns/1ps
`default_nettype none
module token_device
(
	input  wire token_pkg::pins_t  pins,
	input  wire logic              b_we_n,
	input  wire logic [2:0]        b_idx,
	input  wire logic              b_d0,
	output logic                   b_flag,
	output logic [15:0]            data_in
);
	import token_pkg::*;
	// Power-up state is left dirty on purpose
	logic [7:0] la = 8'hf0;
	logic [7:0] lb = 8'h0f;
	logic [7:0] own_a = 8'h0f;
	logic [7:0] own_b = 8'hf0;
	logic       held = 1'b0;
	logic       rd;
	// Latch a request, then settle who holds the token
	task automatic put(input logic s, input logic [2:0] i, input logic v);
		if (s)
			lb[i] = v;
		else
			la[i] = v;
		if (own_a[i] && la[i])
			own_a[i] = 1'b0;
		if (own_b[i] && lb[i])
			own_b[i] = 1'b0;
		if (!own_a[i] && !own_b[i] && !la[i])
			own_a[i] = 1'b1;
		else if (!own_a[i] && !own_b[i] && !lb[i])
			own_b[i] = 1'b1;
	endtask
	// Writes land as the strobe opens
	always @(negedge pins.write_n)
		if (!pins.token_space_select_n)
			put(1'b0, pins.addr[2:0], pins.data_out[0]);
	always @(negedge b_we_n)
		put(1'b1, b_idx, b_d0);
	assign rd = !pins.token_space_select_n && !pins.output_enable_n;
	// Held so a far-side write cannot tear a read
	always @(posedge rd)
		held = !own_a[pins.addr[2:0]];
	always @*
		data_in = rd ? {16{held}} : {16{!held}};
	always @*
		b_flag = !own_b[b_idx];
endmodule
`default_nettype wire

// *** token_host.sv ***
// Host controller that claims, releases and reads token flags on one port
//
// Overview of operation
// - Host drops select and output enable between every pair of reads.
// - A claim writes zero first, then reads back to confirm ownership.
// - After a failed claim the host reports the flag as taken and returns to idle.
// - Init command writes one to each flag from the requested index up to the last of the eight.
`timescale 1ns/1ps
`default_nettype none
module token_host
(
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic              req_valid,
	input  wire token_pkg::request_t req,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output token_pkg::result_t     rsp,
	output token_pkg::pins_t       pins,
	input  wire logic [token_pkg::DATA_W-1:0] data_in
);
	import token_pkg::*;

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	// Gray-coded along idle -> write -> gap -> read -> done
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h0,
		ST_WRITE = 3'h1,
		ST_GAP   = 3'h3,
		ST_READ  = 3'h2,
		ST_DONE  = 3'h6
	} phase_t;

	typedef struct packed
	{
		phase_t             phase;
		cmd_t               cmd;
		logic [INDEX_W-1:0] index;
		logic [DATA_W-1:0]  sync1;
		logic [DATA_W-1:0]  sync2;
		logic               rsp_valid;
		result_t            rsp;
		pins_t              pins;
	} host_state_t;

	host_state_t state_r;
	host_state_t state_nxt;
	logic        strobe_start;
	logic        strobe_done;

	// ------------------------------------------------------------
	// Address and pin helpers
	// ------------------------------------------------------------
	// Address with the flag index on the three lowest lines
	function automatic logic [ADDR_W-1:0] flag_addr(
		input logic [INDEX_W-1:0] idx);
		flag_addr = {{(ADDR_W-INDEX_W){1'b0}}, idx};
	endfunction

	// Pin set for an idle, deselected port
	function automatic pins_t idle_pins(input logic [INDEX_W-1:0] idx);
		idle_pins = '{token_space_select_n: 1'b1, output_enable_n: 1'b1,
			write_n: 1'b1, addr: flag_addr(idx), data_out: '0,
			data_oe: 1'b0};
	endfunction

	// One timer paces strobes and gaps alike, so their widths stay equal
	strobe_timer u_timer
	(
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.start   (strobe_start),
		.done    (strobe_done)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt           = state_r;
		state_nxt.sync1     = data_in;
		state_nxt.sync2     = state_r.sync1;
		state_nxt.rsp_valid = 1'b0;
		strobe_start        = 1'b0;
		case (state_r.phase)
			ST_IDLE:
			begin
				state_nxt.pins = idle_pins(state_r.index);
				if (req_valid)
				begin
					// Keep the command; the request may drop now
					state_nxt.cmd       = req.cmd;
					state_nxt.index     = req.index;
					strobe_start        = 1'b1;
					state_nxt.pins.addr = flag_addr(req.index);
					state_nxt.pins.token_space_select_n = 1'b0;
					if (req.cmd == CMD_READ)
					begin
						state_nxt.pins.output_enable_n = 1'b0;
						state_nxt.phase = ST_READ;
					end
					else
					begin
						// Claim writes zero before any read
						state_nxt.pins.write_n  = 1'b0;
						state_nxt.pins.data_oe  = 1'b1;
						state_nxt.pins.data_out =
							{{(DATA_W-1){1'b0}},
							req.cmd != CMD_CLAIM};
						state_nxt.phase = ST_WRITE;
					end
				end
			end
			ST_WRITE:
			begin
				// Close the write strobe, then hold a deselected gap
				if (strobe_done)
				begin
					state_nxt.pins  = idle_pins(state_r.index);
					strobe_start    = 1'b1;
					state_nxt.phase = ST_GAP;
				end
			end
			ST_GAP:
			begin
				// Deselected gap so the next read latches afresh
				if (strobe_done)
				begin
					strobe_start = 1'b1;
					if (state_r.cmd == CMD_CLAIM)
					begin
						// Read back the flag to learn whether the claim won
						state_nxt.pins.token_space_select_n = 1'b0;
						state_nxt.pins.output_enable_n = 1'b0;
						state_nxt.phase = ST_READ;
					end
					else if (state_r.cmd == CMD_INIT &&
						state_r.index != INDEX_W'(FLAG_COUNT - 1))
					begin
						// Walk upward to the last flag, one write per pass
						state_nxt.index = state_r.index + 3'h1;
						state_nxt.pins.addr =
							flag_addr(state_r.index + 3'h1);
						state_nxt.pins.token_space_select_n = 1'b0;
						state_nxt.pins.write_n  = 1'b0;
						state_nxt.pins.data_oe  = 1'b1;
						state_nxt.pins.data_out = {{(DATA_W-1){1'b0}}, 1'b1};
						state_nxt.phase = ST_WRITE;
					end
					else
					begin
						strobe_start    = 1'b0;
						state_nxt.rsp   = '{granted: 1'b0, flag: 1'b1};
						state_nxt.phase = ST_DONE;
					end
				end
			end
			ST_READ:
			begin
				// Hold the strobe long enough for the sampled data to settle
				if (strobe_done)
				begin
					// Only bit zero is needed since all lines agree
					state_nxt.rsp.flag    = state_r.sync2[0];
					state_nxt.rsp.granted = !state_r.sync2[0];
					state_nxt.pins        = idle_pins(state_r.index);
					state_nxt.phase       = ST_DONE;
				end
			end
			ST_DONE:
			begin
				// Always leave one deselected cycle before the next access
				state_nxt.rsp_valid = 1'b1;
				state_nxt.phase     = ST_IDLE;
			end
			default:
			begin
				// An illegal phase falls back to a deselected idle port
				state_nxt.phase = ST_IDLE;
				state_nxt.pins  = idle_pins(INDEX_RESET);
			end
		endcase
	end

	// State register; every pin starts deselected
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			// Constants only, so reset never depends on other logic
			state_r       <= '0;
			state_r.phase <= ST_IDLE;
			state_r.pins  <= '{token_space_select_n: 1'b1,
				output_enable_n: 1'b1, write_n: 1'b1, addr: '0,
				data_out: '0, data_oe: 1'b0};
		end
		else
			state_r <= state_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Ready is combinational so a request is taken on the first idle edge
	assign req_ready = (state_r.phase == ST_IDLE);
	assign rsp_valid = state_r.rsp_valid;
	assign rsp       = state_r.rsp;
	assign pins      = state_r.pins;
endmodule
`default_nettype wire

// *** token_pkg.sv ***
// Package with constants and carrier types for the token flag controller
package token_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int unsigned DATA_W  = 16;
	localparam int unsigned INDEX_W = 3;
	localparam int unsigned ADDR_W  = 15;
	localparam int unsigned FLAG_COUNT = 8;

	// ------------------------------------------------------------
	// Timing (40 MHz reference, 25 ns period)
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned STROBE_NS     = 50;
	localparam int unsigned STROBE_CYC    =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] STROBE_CNT = 2'(STROBE_CYC);
	localparam logic [1:0] CNT_RESET  = 2'h0;

	// ------------------------------------------------------------
	// Commands from the user side
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CMD_CLAIM   = 2'h0,
		CMD_RELEASE = 2'h1,
		CMD_READ    = 2'h2,
		CMD_INIT    = 2'h3
	} cmd_t;

	typedef struct packed
	{
		cmd_t               cmd;
		logic [INDEX_W-1:0] index;
	} request_t;

	typedef struct packed
	{
		logic granted;
		logic flag;
	} result_t;

	// Pins toward the device port
	typedef struct packed
	{
		logic               token_space_select_n;
		logic               output_enable_n;
		logic               write_n;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  data_out;
		logic               data_oe;
	} pins_t;

	localparam logic [INDEX_W-1:0] INDEX_RESET = 3'h0;

endpackage
